// >>> core/tf_pkg.sv
// Purpose: Shared constants and carriers for the task-file register bank
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Selector codes address the bank from the frame-field side
// Behaviour
// R1: Data moves through a sixteen-bit data port
// R2: Error causes matter only when status error set
// R3: Bad block sets error bit seven
// R4: Uncorrectable data error sets error bit six
// R5: Missing or wrong sector id sets bit four
// R6: Aborted or invalid command sets bit two
// R7: General error sets error bit zero
// R8: Error bits five, three, one read zero
// R9: Sector count zero means 256 sectors
// R10: Successful command leaves sector count zero
// R11: Failed command leaves remaining sectors in count
// R12: Sector number gives start sector or LBA 7-0
// R13: Cylinder low gives cylinder low or LBA 15-8
// R14: Task-file values travel inside frame register fields
// R15: One device per channel, no drive selection
// R16: No alternate status register is offered
// R17: Interface detect output held at ground
// R18: Host leaves device sleep input unconnected
// R19: Cylinder high and head nibble give LBA 27-16
// R20: Status error bit set when command ends failing
// R21: Error causes cleared when a new command starts
package tf_pkg;

   // Width of the data port and of the byte registers
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;

   // Task-file selector codes, in classic command-block order
   localparam logic [2:0] SEL_DATA = 3'h0;
   localparam logic [2:0] SEL_ERR_FEAT = 3'h1;
   localparam logic [2:0] SEL_COUNT = 3'h2;
   localparam logic [2:0] SEL_SECTOR = 3'h3;
   localparam logic [2:0] SEL_CYL_LOW = 3'h4;

   // Error register field positions
   localparam int BIT_BAD_BLOCK = 7;
   localparam int BIT_UNCORRECTABLE = 6;
   localparam int BIT_ID_MISSING = 4;
   localparam int BIT_ABORTED = 2;
   localparam int BIT_GENERAL = 0;
   localparam int CAUSE_N = 5;

   // Reset values
   localparam logic [7:0] ERR_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // A zero count stands for this many sectors
   localparam logic [8:0] FULL_COUNT = 9'h100;

   // Command tracking states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } cmd_state_e;

   // One access from the frame register-field side
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] sel;
      logic [15:0] wdata;
   } tf_req_s;

   // Failure causes reported by the media controller
   typedef struct packed {
      logic bad_block;
      logic uncorrectable;
      logic id_missing;
      logic aborted;
      logic general;
   } err_evt_s;

endpackage

// >>> core/tf_regs.sv
// Purpose: Task-file data, error, feature, count and low address registers
// Assumes: Frame layer presents register fields as single-cycle accesses
// Notes: Read data and write side effects appear one clock after a request
`timescale 1ns/1ps
`default_nettype none

module tf_regs (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   // Register-field access from the frame layer
   input wire tf_pkg::tf_req_s TF_REQ_I,
   output logic [15:0] TF_RDATA_O,
   output logic TF_RVALID_O,
   // Data buffer side, one word per pulse
   output logic [15:0] BUF_WDATA_O,
   output logic BUF_WVALID_O,
   input wire logic [15:0] BUF_RDATA_I,
   output logic BUF_RD_O,
   // Command progress from the media controller
   input wire logic CMD_START_I,
   input wire logic SECTOR_DONE_I,
   input wire logic CMD_END_I,
   input wire logic CMD_FAIL_I,
   input wire tf_pkg::err_evt_s ERR_EVT_I,
   // Upper address bits held outside this bank
   input wire logic [7:0] CYL_HIGH_I,
   input wire logic [3:0] HEAD_SELECT_I,
   // Decoded transfer parameters
   output logic [8:0] XFER_SECTORS_O,
   output logic [27:0] LBA_O,
   output logic [7:0] START_SECTOR_O,
   output logic [15:0] CYLINDER_O,
   output logic [7:0] FEATURE_O,
   output logic STATUS_ERR_O,
   output logic CMD_BUSY_O,
   // Card pins
   input wire logic CARD_DETECT_IN_I,
   output logic CARD_DETECT_OUT_O,
   input wire logic DEVICE_SLEEP_INPUT_I,
   output logic INTERFACE_DETECT_O
);

   // Selector match, used by read and write decode alike
   function automatic logic sel_hit(input tf_pkg::tf_req_s req,
                                    input logic [2:0] code);
      sel_hit = (req.sel == code);
   endfunction

   // Count of sectors a register value asks for
   function automatic logic [8:0] sectors_of(input logic [7:0] cnt);
      if (cnt == tf_pkg::BYTE_RESET) begin
         sectors_of = tf_pkg::FULL_COUNT; // R9
      end else begin
         sectors_of = {1'b0, cnt};
      end
   endfunction

   // Command tracking state
   tf_pkg::cmd_state_e state_q;
   tf_pkg::cmd_state_e state_d;

   // Stored task-file bytes
   logic [7:0] err_byte; // Failure causes, assembled from the cause flops
   logic [7:0] feat_q; // Feature byte, write only from host
   logic [7:0] count_q; // Sector count as the host sees it
   logic [7:0] sect_q; // Start sector or LBA 7-0
   logic [7:0] cyl_lo_q; // Cylinder low or LBA 15-8

   // Sectors still owed in the running command
   logic [8:0] remain_q;

   // Output holding flops
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic [15:0] bwdata_q;
   logic bwvalid_q;
   logic brd_q;
   logic [8:0] xfer_q;
   logic [27:0] lba_q;
   logic stat_err_q;
   logic cdo_q;
   logic interface_detect_q;
   logic busy_q; // Running flag, kept in a flop of its own
   logic [7:0] cyl_hi_q; // Cylinder high copy for the cylinder output

   // Causes flattened in error-register bit order
   logic [4:0] evt_vec;

   // Decoded write strobes and the data read strobe
   logic wr_data;
   logic wr_feat;
   logic wr_count;
   logic wr_sect;
   logic wr_cyl_lo;
   logic rd_data;

   // Write and read decode
   always_comb begin
      wr_data = TF_REQ_I.wr && sel_hit(TF_REQ_I, tf_pkg::SEL_DATA);
      // Error and feature share a selector: reads see causes, writes features
      wr_feat = TF_REQ_I.wr && sel_hit(TF_REQ_I, tf_pkg::SEL_ERR_FEAT);
      wr_count = TF_REQ_I.wr && sel_hit(TF_REQ_I, tf_pkg::SEL_COUNT);
      wr_sect = TF_REQ_I.wr && sel_hit(TF_REQ_I, tf_pkg::SEL_SECTOR);
      wr_cyl_lo = TF_REQ_I.wr && sel_hit(TF_REQ_I, tf_pkg::SEL_CYL_LOW);
      rd_data = TF_REQ_I.rd && sel_hit(TF_REQ_I, tf_pkg::SEL_DATA);
   end

   // Flatten causes into one vector, bad block high and general in bit zero
   always_comb begin
      evt_vec = {ERR_EVT_I.bad_block, ERR_EVT_I.uncorrectable,
                 ERR_EVT_I.id_missing, ERR_EVT_I.aborted,
                 ERR_EVT_I.general};
   end

   // Next command state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         tf_pkg::ST_IDLE: begin
            if (CMD_START_I) begin
               state_d = tf_pkg::ST_RUN;
            end
         end
         tf_pkg::ST_RUN: begin
            if (CMD_END_I) begin
               state_d = tf_pkg::ST_IDLE;
            end
         end
         default: begin
            // Illegal code recovers to idle
            state_d = tf_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   // Busy is registered beside the state so the port needs no decode gate;
   // it follows the next state, so it shows the same timing as the state
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         state_q <= tf_pkg::ST_IDLE;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q <= (state_d == tf_pkg::ST_RUN);
      end
   end

   // Error cause bits, one flop per documented cause
   // Other positions never get a cause flop and stay zero
   localparam int CAUSE_POS [5] = '{tf_pkg::BIT_BAD_BLOCK,
                                    tf_pkg::BIT_UNCORRECTABLE,
                                    tf_pkg::BIT_ID_MISSING,
                                    tf_pkg::BIT_ABORTED,
                                    tf_pkg::BIT_GENERAL};
   logic [4:0] cause_q;
   genvar gi;
   generate
      for (gi = 0; gi < tf_pkg::CAUSE_N; gi++) begin : g_cause
         // An event in the start cycle survives the clear
         always_ff @(posedge REF_CLK_I) begin
            if (SYS_RST_I) begin
               cause_q[gi] <= 1'b0;
            end else if (evt_vec[gi]) begin
               cause_q[gi] <= 1'b1; // R3 R4 R5 R6 R7
            end else if (CMD_START_I) begin
               cause_q[gi] <= 1'b0; // R21
            end
         end
      end
   endgenerate

   // Assemble the byte; unlisted bits are constant zero
   // Cause flop i holds bit i of the flattened vector, general first,
   // while the position table lists bad block first, hence the reversal
   always_comb begin
      err_byte = tf_pkg::ERR_RESET; // R8
      for (int i = 0; i < tf_pkg::CAUSE_N; i++) begin
         err_byte[CAUSE_POS[tf_pkg::CAUSE_N - 1 - i]] = cause_q[i]; // R3 R4 R5 R6 R7
      end
   end

   // Feature byte, passed straight to the media controller
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         feat_q <= tf_pkg::BYTE_RESET;
      end else if (wr_feat) begin
         feat_q <= TF_REQ_I.wdata[7:0];
      end
   end

   // Low address bytes from the host
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         sect_q <= tf_pkg::BYTE_RESET;
         cyl_lo_q <= tf_pkg::BYTE_RESET;
      end else begin
         if (wr_sect) begin
            sect_q <= TF_REQ_I.wdata[7:0]; // R12
         end
         if (wr_cyl_lo) begin
            cyl_lo_q <= TF_REQ_I.wdata[7:0]; // R13
         end
      end
   end

   // Cylinder high held in a flop so the cylinder output is registered
   // The copy lags the outside register by one clock, like the address;
   // a host must not expect the new byte in the very next cycle
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         cyl_hi_q <= tf_pkg::BYTE_RESET;
      end else begin
         cyl_hi_q <= CYL_HIGH_I; // R19
      end
   end

   // Remaining sectors of the running command
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         remain_q <= 9'h000;
      end else if (CMD_START_I && state_q == tf_pkg::ST_IDLE) begin
         remain_q <= sectors_of(count_q); // R9
      end else if (SECTOR_DONE_I && state_q == tf_pkg::ST_RUN
                   && remain_q != 9'h000) begin
         remain_q <= remain_q - 9'h001;
      end
   end

   // Sector count register; completion rewrites it
   // A full 256 owed reads back as zero, the only 8-bit form of it
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         count_q <= tf_pkg::BYTE_RESET;
      end else if (CMD_END_I && state_q == tf_pkg::ST_RUN) begin
         if (CMD_FAIL_I) begin
            count_q <= remain_q[7:0]; // R11
         end else begin
            count_q <= tf_pkg::BYTE_RESET; // R10
         end
      end else if (wr_count) begin
         count_q <= TF_REQ_I.wdata[7:0];
      end
   end

   // Status error bit: set at a failing end, cleared at a new start
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         stat_err_q <= 1'b0;
      end else if (CMD_END_I && state_q == tf_pkg::ST_RUN
                   && (CMD_FAIL_I || evt_vec != 5'h00
                       || cause_q != 5'h00)) begin
         stat_err_q <= 1'b1; // R20 R2
      end else if (CMD_START_I) begin
         stat_err_q <= 1'b0;
      end
   end

   // Register-field reads; unmapped selectors answer zero
   // No alternate status image is decoded here
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         rdata_q <= tf_pkg::WORD_RESET;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= TF_REQ_I.rd;
         if (!TF_REQ_I.rd) begin
            rdata_q <= tf_pkg::WORD_RESET;
         end else if (rd_data) begin
            rdata_q <= BUF_RDATA_I; // R1
         end else if (sel_hit(TF_REQ_I, tf_pkg::SEL_ERR_FEAT)) begin
            rdata_q <= {8'h00, err_byte}; // R2
         end else if (sel_hit(TF_REQ_I, tf_pkg::SEL_COUNT)) begin
            rdata_q <= {8'h00, count_q};
         end else if (sel_hit(TF_REQ_I, tf_pkg::SEL_SECTOR)) begin
            rdata_q <= {8'h00, sect_q};
         end else if (sel_hit(TF_REQ_I, tf_pkg::SEL_CYL_LOW)) begin
            rdata_q <= {8'h00, cyl_lo_q};
         end else begin
            rdata_q <= tf_pkg::WORD_RESET; // R16
         end
      end
   end

   // Data port toward the sector buffer, full word each way
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         bwdata_q <= tf_pkg::WORD_RESET;
         bwvalid_q <= 1'b0;
         brd_q <= 1'b0;
      end else begin
         bwvalid_q <= wr_data; // R1
         brd_q <= rd_data; // R1
         if (wr_data) begin
            bwdata_q <= TF_REQ_I.wdata;
         end
      end
   end

   // Decoded address and transfer length for the media side
   // Drive number is not taken: one device per channel
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         lba_q <= 28'h0000000;
         xfer_q <= 9'h000;
      end else begin
         lba_q <= {HEAD_SELECT_I, CYL_HIGH_I, cyl_lo_q, sect_q}; // R19 R15
         xfer_q <= sectors_of(count_q); // R9
      end
   end

   // Card pins: detect loop-back and grounded interface detect
   // Sleep requests are ignored since the state is unsupported
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         cdo_q <= 1'b0;
         interface_detect_q <= 1'b0;
      end else begin
         cdo_q <= CARD_DETECT_IN_I && !(DEVICE_SLEEP_INPUT_I && 1'b0); // R18
         interface_detect_q <= 1'b0; // R17
      end
   end

   // Port assignments, all from flops
   assign TF_RDATA_O = rdata_q; // R14
   assign TF_RVALID_O = rvalid_q;
   assign BUF_WDATA_O = bwdata_q;
   assign BUF_WVALID_O = bwvalid_q;
   assign BUF_RD_O = brd_q;
   assign XFER_SECTORS_O = xfer_q;
   assign LBA_O = lba_q;
   assign START_SECTOR_O = sect_q;
   assign CYLINDER_O = {cyl_hi_q, cyl_lo_q};
   assign FEATURE_O = feat_q;
   assign STATUS_ERR_O = stat_err_q;
   assign CMD_BUSY_O = busy_q;
   assign CARD_DETECT_OUT_O = cdo_q;
   assign INTERFACE_DETECT_O = interface_detect_q;

endmodule

`default_nettype wire

// >>> sim/tf_media.sv
// Purpose: Sector buffer model behind the data port
// Assumes: Advance pulse steps to the next word
// Notes: Words count up so a stale word is caught
`timescale 1ns/1ps
`default_nettype none

module tf_media (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic adv_i,
   output logic [15:0] word_o
);
   logic [15:0] word_q; // Current buffer word

   // Step the word on each advance
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_q <= 16'h1234;
      end else if (adv_i) begin
         word_q <= word_q + 16'h0001;
      end
   end
   assign word_o = word_q;
endmodule
`default_nettype wire

// >>> sim/tf_regs_checker.sv
// Purpose: Port-level checks for the task-file register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Attached by bind; sees only the bank's ports
`timescale 1ns/1ps
`default_nettype none

module tf_regs_checker (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire tf_pkg::tf_req_s TF_REQ_I,
   input wire logic [15:0] TF_RDATA_O,
   input wire logic TF_RVALID_O,
   input wire logic [15:0] BUF_WDATA_O,
   input wire logic BUF_WVALID_O,
   input wire logic [15:0] BUF_RDATA_I,
   input wire logic BUF_RD_O,
   input wire logic CMD_START_I,
   input wire logic CMD_END_I,
   input wire logic CMD_FAIL_I,
   input wire tf_pkg::err_evt_s ERR_EVT_I,
   input wire logic [7:0] CYL_HIGH_I,
   input wire logic [3:0] HEAD_SELECT_I,
   input wire logic [27:0] LBA_O,
   input wire logic STATUS_ERR_O,
   input wire logic CMD_BUSY_O,
   input wire logic INTERFACE_DETECT_O
);
   // Single domain, so clock and reset are given once
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   property p_rvalid; TF_REQ_I.rd |=> TF_RVALID_O; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_bufw; TF_REQ_I.wr && TF_REQ_I.sel == tf_pkg::SEL_DATA
      |=> BUF_WVALID_O && BUF_WDATA_O == $past(TF_REQ_I.wdata); endproperty
   a_bufw: assert property (p_bufw) else $error("data word not passed on");
   property p_bufr; TF_REQ_I.rd && TF_REQ_I.sel == tf_pkg::SEL_DATA
      |=> BUF_RD_O && TF_RDATA_O == $past(BUF_RDATA_I); endproperty
   a_bufr: assert property (p_bufr) else $error("data word not returned");
   // Error byte: upper half and unused bits must read zero
   property p_zero; TF_RVALID_O && $past(TF_REQ_I.sel) == tf_pkg::SEL_ERR_FEAT
      |-> TF_RDATA_O[15:8] == 8'h00 && {TF_RDATA_O[5], TF_RDATA_O[3], TF_RDATA_O[1]} == 3'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("unused error bit set");
   property p_interface_detect; INTERFACE_DETECT_O == 1'b0; endproperty
   a_interface_detect: assert property (p_interface_detect) else $error("detect pin not low");
   property p_start; CMD_START_I && !CMD_BUSY_O && ERR_EVT_I == 5'h00 |=> !STATUS_ERR_O;
   endproperty
   a_start: assert property (p_start) else $error("error kept over new command");
   property p_fail; CMD_BUSY_O && CMD_END_I && CMD_FAIL_I |=> STATUS_ERR_O && !CMD_BUSY_O;
   endproperty
   a_fail: assert property (p_fail) else $error("failed command not flagged");
   // Upper address follows the outside registers one cycle later
   property p_lba; !$past(SYS_RST_I) |-> LBA_O[27:24] == $past(HEAD_SELECT_I)
      && LBA_O[23:16] == $past(CYL_HIGH_I); endproperty
   a_lba: assert property (p_lba) else $error("upper address wrong");
endmodule

bind tf_regs tf_regs_checker tf_regs_checker_i (.*);
`default_nettype wire

// >>> sim/tf_regs_tb.sv
// Purpose: Self-checking bench for the task-file register bank
// Assumes: 10 MHz clock, reset held six cycles
// Notes: Requests launched at rising edges, results read 1 ns later
`timescale 1ns/1ps
`default_nettype none

module tf_regs_tb;
   logic ref_clk = 1'b0; // 100 ns period
   logic sys_rst = 1'b1;
   tf_pkg::tf_req_s req = '0;
   tf_pkg::err_evt_s evt = '0;
   logic start = 1'b0, sdone = 1'b0, cend = 1'b0, cfail = 1'b0, card_detect_in = 1'b0;
   logic [7:0] cyl_hi = 8'h00, ssec, feat;
   logic [3:0] head = 4'h0;
   logic [15:0] rdata, bwdata, bword, cyl;
   logic rvalid, bwvalid, brd, st_err, busy, card_detect_out, interface_detect;
   logic [8:0] xfer;
   logic [27:0] lba;
   int mismatches = 0, n_tests = 0, cyc = 0;
   int pos [5] = '{0, 2, 4, 6, 7}; // Error bit of each cause, general first

   always #50 ref_clk = ~ref_clk;

   tf_regs tf_regs_i (.REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst), .TF_REQ_I(req),
      .TF_RDATA_O(rdata), .TF_RVALID_O(rvalid), .BUF_WDATA_O(bwdata),
      .BUF_WVALID_O(bwvalid), .BUF_RDATA_I(bword), .BUF_RD_O(brd), .CMD_START_I(start),
      .SECTOR_DONE_I(sdone), .CMD_END_I(cend), .CMD_FAIL_I(cfail), .ERR_EVT_I(evt),
      .CYL_HIGH_I(cyl_hi), .HEAD_SELECT_I(head), .XFER_SECTORS_O(xfer), .LBA_O(lba),
      .START_SECTOR_O(ssec), .CYLINDER_O(cyl), .FEATURE_O(feat), .STATUS_ERR_O(st_err),
      .CMD_BUSY_O(busy), .CARD_DETECT_IN_I(card_detect_in), .CARD_DETECT_OUT_O(card_detect_out),
      .DEVICE_SLEEP_INPUT_I(1'b0), .INTERFACE_DETECT_O(interface_detect));

   tf_media tf_media_i (.clk_i(ref_clk), .rst_i(sys_rst), .adv_i(brd), .word_o(bword));

   // Verdict and end of run
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Single comparison for every kind of result
   task automatic chk(input logic [27:0] got, input logic [27:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // One register write, taken at the second edge
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      @(posedge ref_clk) req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
      @(posedge ref_clk) req <= '0;
   endtask

   // One register read; data stands from the taking edge, checked 1 ns later
   task automatic rd(input logic [2:0] s, input logic [15:0] exp);
      @(posedge ref_clk) req <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 16'h0000};
      @(posedge ref_clk) req <= '0;
      #1 chk(28'(rdata), 28'(exp));
   endtask

   // Media-side command: start, one cause, sectors, end
   task automatic cmd(input logic [7:0] cnt, input int ns, input logic f,
                      input tf_pkg::err_evt_s ev);
      wr(tf_pkg::SEL_COUNT, {8'h00, cnt});
      @(posedge ref_clk) start <= 1'b1;
      @(posedge ref_clk) start <= 1'b0;
      evt <= ev;
      @(posedge ref_clk) evt <= '0;
      repeat (ns) begin
         sdone <= 1'b1;
         @(posedge ref_clk) sdone <= 1'b0;
         @(posedge ref_clk);
      end
      cend <= 1'b1;
      cfail <= f;
      @(posedge ref_clk) cend <= 1'b0;
      cfail <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      cyl_hi <= 8'hC3;
      head <= 4'hA;
      card_detect_in <= 1'b1;
      rd(tf_pkg::SEL_ERR_FEAT, 16'h0000);
      rd(3'h5, 16'h0000);
      wr(tf_pkg::SEL_SECTOR, 16'h005A);
      wr(tf_pkg::SEL_CYL_LOW, 16'h0096);
      rd(tf_pkg::SEL_SECTOR, 16'h005A);
      rd(tf_pkg::SEL_CYL_LOW, 16'h0096);
      chk(lba, 28'hAC3965A);
      chk({ssec, cyl}, {8'h5A, 16'hC396});
      chk({interface_detect, card_detect_out}, 2'b01);
      wr(tf_pkg::SEL_ERR_FEAT, 16'h00E7);
      rd(tf_pkg::SEL_ERR_FEAT, 16'h0000);
      chk(feat, 8'hE7);
      wr(tf_pkg::SEL_DATA, 16'hBEEF);
      #1 chk({bwvalid, bwdata}, {1'b1, 16'hBEEF});
      rd(tf_pkg::SEL_DATA, 16'h1234);
      rd(tf_pkg::SEL_DATA, 16'h1235);
      wr(tf_pkg::SEL_COUNT, 16'h0000);
      rd(tf_pkg::SEL_COUNT, 16'h0000);
      chk(xfer, 9'h100);
      // Each cause in turn, with a fresh command each time
      for (int b = 0; b < 5; b++) begin
         cmd(8'h01, 1, 1'b0, 5'(1 << b));
         rd(tf_pkg::SEL_ERR_FEAT, 16'h0001 << pos[b]);
         chk(st_err, 1'b1);
         rd(tf_pkg::SEL_COUNT, 16'h0000);
      end
      cmd(8'h02, 2, 1'b0, '0);
      rd(tf_pkg::SEL_ERR_FEAT, 16'h0000);
      chk(st_err, 1'b0);
      rd(tf_pkg::SEL_COUNT, 16'h0000);
      cmd(8'h03, 1, 1'b1, '0);
      rd(tf_pkg::SEL_COUNT, 16'h0002);
      chk(st_err, 1'b1);
      chk(xfer, 9'h002);
      // Zero count owes 256; one sector done leaves 255 to report
      cmd(8'h00, 1, 1'b1, '0);
      rd(tf_pkg::SEL_COUNT, 16'h00FF);
      chk(xfer, 9'h0FF);
      wrap_up();
   end
endmodule
`default_nettype wire
